// >>> logic/bcc_charge_fsm.sv
// Battery charge cycle state machine with phase display and thermal derating
`timescale 1ns/1ps
`default_nettype none
module bcc_charge_fsm #(
  parameter int VOLT_W = bcc_pkg::VOLT_W,
  parameter int MIN_W  = bcc_pkg::MIN_W,
  parameter int DAY_W  = bcc_pkg::DAY_W
) (
  // Clock and reset
  input  wire logic                        CORE_CLK_I,
  input  wire logic                        SRST_I,
  // Timebase pulses and time of day
  input  wire logic                        MINUTE_TICK_I,
  input  wire logic                        DAY_TICK_I,
  input  wire logic [bcc_pkg::HOUR_W-1:0]  HOUR_I,
  // Measurements
  input  wire logic [VOLT_W-1:0]           BATTERY_VOLTAGE_I,
  input  wire logic                        OVER_TEMP_I,
  // Settings
  input  wire logic [VOLT_W-1:0]           BOOST_CEILING_VOLTAGE_I,
  input  wire logic [VOLT_W-1:0]           BOOST_RETURN_VOLTAGE_I,
  input  wire logic [DAY_W-1:0]            BOOST_INTERVAL_DAYS_I,
  input  wire logic [VOLT_W-1:0]           EQUALISE_VOLTAGE_I,
  input  wire logic [MIN_W-1:0]            EQUALISE_DURATION_I,
  input  wire logic [DAY_W-1:0]            EQUALISE_INTERVAL_DAYS_I,
  input  wire logic [VOLT_W-1:0]           ABSORPTION_VOLTAGE_I,
  input  wire logic [MIN_W-1:0]            ABSORPTION_DURATION_I,
  input  wire logic [VOLT_W-1:0]           SWITCHING_MARGIN_I,
  input  wire logic [VOLT_W-1:0]           FLOAT_VOLTAGE_TARGET_I,
  // Debounced button events, one-cycle pulses
  input  wire logic                        SHORT_PUSH_I,
  input  wire logic                        LONG_PUSH_I,
  // Charge control and display
  output logic                             CHARGE_ON_O,
  output logic                             CURRENT_REDUCE_O,
  output logic [1:0]                       PHASE_O,
  output logic [1:0]                       SCREEN_O,
  output logic [1:0]                       SHOW_KIND_O,
  output logic [MIN_W-1:0]                 SHOW_VALUE_O
);

  bcc_pkg::bcc_phase_type  phase_r,  phase_nxt;
  bcc_pkg::bcc_screen_type screen_r, screen_nxt;
  logic [MIN_W-1:0] ceil_cnt_r, ceil_cnt_nxt;
  logic [MIN_W-1:0] ret_cnt_r,  ret_cnt_nxt;
  logic [MIN_W-1:0] ph_tmr_r,   ph_tmr_nxt;
  logic [MIN_W-1:0] eq_age_r,   eq_age_nxt;
  logic [DAY_W-1:0] boost_day_r, boost_day_nxt;
  logic [DAY_W-1:0] eq_day_r,    eq_day_nxt;
  logic             eq_due_r,    eq_due_nxt;
  logic             eq_reached_r, eq_reached_nxt;
  logic             charge_r, charge_nxt;
  logic             reduce_r;
  logic [1:0]       kind_r;
  logic [MIN_W-1:0] value_r;

  // Level comparisons
  wire at_ceiling  = BATTERY_VOLTAGE_I >= BOOST_CEILING_VOLTAGE_I;
  wire below_ret   = BATTERY_VOLTAGE_I <  BOOST_RETURN_VOLTAGE_I;
  wire [VOLT_W-1:0] abs_floor = (ABSORPTION_VOLTAGE_I > SWITCHING_MARGIN_I) ?
                                (ABSORPTION_VOLTAGE_I - SWITCHING_MARGIN_I) : bcc_pkg::VOLT_ZERO;
  wire abs_holding = BATTERY_VOLTAGE_I > abs_floor;
  wire eq_at_volt  = BATTERY_VOLTAGE_I >= EQUALISE_VOLTAGE_I;
  // Floor clamped at zero so a large margin cannot wrap the threshold high
  wire [VOLT_W-1:0] eq_floor = (EQUALISE_VOLTAGE_I > SWITCHING_MARGIN_I) ?
                               (EQUALISE_VOLTAGE_I - SWITCHING_MARGIN_I) : bcc_pkg::VOLT_ZERO;
  wire eq_holding  = eq_reached_r && (BATTERY_VOLTAGE_I > eq_floor);
  wire eq_enabled  = EQUALISE_DURATION_I != bcc_pkg::TIMER_ZERO;
  wire abs_enabled = ABSORPTION_DURATION_I != bcc_pkg::TIMER_ZERO;

  // Qualification events
  wire ceil_done   = ceil_cnt_r >= bcc_pkg::CEIL_MINUTES;
  wire ret_done    = ret_cnt_r  >  bcc_pkg::RETURN_MINUTES;
  wire boost_due   = (BOOST_INTERVAL_DAYS_I != bcc_pkg::DAY_ZERO) && (boost_day_r >= BOOST_INTERVAL_DAYS_I);
  wire eq_start    = eq_due_r && eq_enabled && (HOUR_I == bcc_pkg::EQ_START_HOUR);
  wire eq_timeout  = eq_age_r >= bcc_pkg::EQ_LIMIT_MIN;
  wire eq_done     = (phase_r == bcc_pkg::BCC_EQUALISE) && (ph_tmr_r >= EQUALISE_DURATION_I);
  wire abs_done    = (phase_r == bcc_pkg::BCC_ABSORB) && (ph_tmr_r >= ABSORPTION_DURATION_I);
  wire manual_adv  = LONG_PUSH_I && (screen_r == bcc_pkg::BCC_SCR_PHASE);

  // Phase that follows boost, skipping disabled timed phases
  wire bcc_pkg::bcc_phase_type after_boost =
    (eq_due_r && eq_enabled) ? bcc_pkg::BCC_EQUALISE :
    abs_enabled ? bcc_pkg::BCC_ABSORB : bcc_pkg::BCC_FLOAT;
  wire bcc_pkg::bcc_phase_type after_eq = abs_enabled ? bcc_pkg::BCC_ABSORB : bcc_pkg::BCC_FLOAT;

  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      bcc_pkg::BCC_BOOST: begin
        if (manual_adv || ceil_done) begin
          phase_nxt = after_boost;
        end
      end
      bcc_pkg::BCC_EQUALISE: begin
        if (manual_adv || eq_done || eq_timeout) begin
          phase_nxt = after_eq;
        end
      end
      bcc_pkg::BCC_ABSORB: begin
        if (manual_adv || abs_done) begin
          phase_nxt = bcc_pkg::BCC_FLOAT;
        end
      end
      default: begin
        if (manual_adv) begin
          phase_nxt = bcc_pkg::BCC_BOOST;
        end
      end
    endcase
    // Low voltage and interval returns only act outside boost
    if (phase_r != bcc_pkg::BCC_BOOST && !manual_adv && (ret_done || boost_due)) begin
      phase_nxt = bcc_pkg::BCC_BOOST;
    end
    // Scheduled equalise interrupts float at the start hour
    if (phase_r == bcc_pkg::BCC_FLOAT && !manual_adv && !ret_done && !boost_due && eq_start) begin
      phase_nxt = bcc_pkg::BCC_EQUALISE;
    end
  end

  wire phase_change = phase_nxt != phase_r;

  always_comb begin
    ceil_cnt_nxt = ceil_cnt_r;
    ret_cnt_nxt  = ret_cnt_r;
    ph_tmr_nxt   = ph_tmr_r;
    eq_age_nxt   = eq_age_r;
    if (phase_r != bcc_pkg::BCC_BOOST || !at_ceiling || phase_change) begin
      ceil_cnt_nxt = bcc_pkg::TIMER_ZERO;
    end else if (MINUTE_TICK_I && !ceil_done) begin
      ceil_cnt_nxt = ceil_cnt_r + bcc_pkg::TIMER_ONE;
    end
    if (!below_ret || phase_change || phase_r == bcc_pkg::BCC_BOOST) begin
      ret_cnt_nxt = bcc_pkg::TIMER_ZERO;
    end else if (MINUTE_TICK_I && !ret_done) begin
      ret_cnt_nxt = ret_cnt_r + bcc_pkg::TIMER_ONE;
    end
    // Phase timer holds while voltage sags, so a cloudy spell does not restart it
    if (phase_change) begin
      ph_tmr_nxt = bcc_pkg::TIMER_ZERO;
    end else if (MINUTE_TICK_I && phase_r == bcc_pkg::BCC_ABSORB && abs_holding) begin
      ph_tmr_nxt = ph_tmr_r + bcc_pkg::TIMER_ONE;
    end else if (MINUTE_TICK_I && phase_r == bcc_pkg::BCC_EQUALISE && eq_holding) begin
      ph_tmr_nxt = ph_tmr_r + bcc_pkg::TIMER_ONE;
    end
    if (phase_change || phase_r != bcc_pkg::BCC_EQUALISE) begin
      eq_age_nxt = bcc_pkg::TIMER_ZERO;
    end else if (MINUTE_TICK_I && !eq_timeout) begin
      eq_age_nxt = eq_age_r + bcc_pkg::TIMER_ONE;
    end
  end

  always_comb begin
    boost_day_nxt  = boost_day_r;
    eq_day_nxt     = eq_day_r;
    eq_due_nxt     = eq_due_r;
    eq_reached_nxt = eq_reached_r;
    if (phase_change && phase_nxt == bcc_pkg::BCC_BOOST) begin
      boost_day_nxt = bcc_pkg::DAY_ZERO;
    end else if (DAY_TICK_I && !boost_due) begin
      boost_day_nxt = boost_day_r + bcc_pkg::DAY_ONE;
    end
    // The due flag is set on the interval day; setting wins over clearing
    if (DAY_TICK_I && eq_enabled && (eq_day_r + bcc_pkg::DAY_ONE >= EQUALISE_INTERVAL_DAYS_I)) begin
      eq_day_nxt = bcc_pkg::DAY_ZERO;
      eq_due_nxt = 1'b1;
    end else begin
      if (DAY_TICK_I) begin
        eq_day_nxt = eq_day_r + bcc_pkg::DAY_ONE;
      end
      if (phase_change && phase_r == bcc_pkg::BCC_EQUALISE) begin
        eq_due_nxt = 1'b0;
      end
      if (!eq_enabled) begin
        eq_due_nxt = 1'b0;
      end
    end
    if (phase_r != bcc_pkg::BCC_EQUALISE || phase_change) begin
      eq_reached_nxt = 1'b0;
    end else if (eq_at_volt) begin
      eq_reached_nxt = 1'b1;
    end
  end

  // Charge switch: held on in boost, bang-bang regulation toward the phase target in the other phases
  always_comb begin
    case (phase_r)
      bcc_pkg::BCC_BOOST:    charge_nxt = 1'b1;
      bcc_pkg::BCC_EQUALISE: charge_nxt = BATTERY_VOLTAGE_I < EQUALISE_VOLTAGE_I;
      bcc_pkg::BCC_ABSORB:   charge_nxt = BATTERY_VOLTAGE_I < ABSORPTION_VOLTAGE_I;
      default:               charge_nxt = BATTERY_VOLTAGE_I < FLOAT_VOLTAGE_TARGET_I;
    endcase
  end

  // Screen selection
  always_comb begin
    screen_nxt = screen_r;
    if (screen_r == bcc_pkg::BCC_SCR_BATTERY && LONG_PUSH_I) begin
      screen_nxt = bcc_pkg::BCC_SCR_PHASE;
    end else if (screen_r == bcc_pkg::BCC_SCR_PHASE && SHORT_PUSH_I) begin
      screen_nxt = bcc_pkg::BCC_SCR_BATTERY;
    end
  end

  wire timed_phase = phase_r == bcc_pkg::BCC_EQUALISE || phase_r == bcc_pkg::BCC_ABSORB;
  wire [MIN_W-1:0] volt_wide = MIN_W'(BATTERY_VOLTAGE_I);
  wire [1:0] kind_nxt = (screen_r == bcc_pkg::BCC_SCR_PHASE && timed_phase) ?
                        bcc_pkg::BCC_SHOW_TIMER : bcc_pkg::BCC_SHOW_VOLTAGE;
  wire [MIN_W-1:0] value_nxt = (kind_nxt == bcc_pkg::BCC_SHOW_TIMER) ? ph_tmr_r : volt_wide;

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      phase_r      <= bcc_pkg::BCC_BOOST;
      screen_r     <= bcc_pkg::BCC_SCR_BATTERY;
      ceil_cnt_r   <= bcc_pkg::TIMER_ZERO;
      ret_cnt_r    <= bcc_pkg::TIMER_ZERO;
      ph_tmr_r     <= bcc_pkg::TIMER_ZERO;
      eq_age_r     <= bcc_pkg::TIMER_ZERO;
      boost_day_r  <= bcc_pkg::DAY_ZERO;
      eq_day_r     <= bcc_pkg::DAY_ZERO;
      eq_due_r     <= 1'b0;
      eq_reached_r <= 1'b0;
      charge_r     <= 1'b0;
      reduce_r     <= 1'b0;
      kind_r       <= bcc_pkg::BCC_SHOW_VOLTAGE;
      value_r      <= bcc_pkg::TIMER_ZERO;
    end else begin
      phase_r      <= phase_nxt;
      screen_r     <= screen_nxt;
      ceil_cnt_r   <= ceil_cnt_nxt;
      ret_cnt_r    <= ret_cnt_nxt;
      ph_tmr_r     <= ph_tmr_nxt;
      eq_age_r     <= eq_age_nxt;
      boost_day_r  <= boost_day_nxt;
      eq_day_r     <= eq_day_nxt;
      eq_due_r     <= eq_due_nxt;
      eq_reached_r <= eq_reached_nxt;
      charge_r     <= charge_nxt;
      reduce_r     <= OVER_TEMP_I;
      kind_r       <= kind_nxt;
      value_r      <= value_nxt;
    end
  end

  assign CHARGE_ON_O      = charge_r;
  assign CURRENT_REDUCE_O = reduce_r;
  assign PHASE_O          = phase_r;
  assign SCREEN_O         = screen_r;
  assign SHOW_KIND_O      = kind_r;
  assign SHOW_VALUE_O     = value_r;

  a_ceiling_advance: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (phase_r == bcc_pkg::BCC_BOOST && ceil_done) |=> (phase_r != bcc_pkg::BCC_BOOST))
    else $error("boost did not leave after ceiling time");
  a_return_boost: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (phase_r != bcc_pkg::BCC_BOOST && ret_done && !manual_adv) |=> (phase_r == bcc_pkg::BCC_BOOST))
    else $error("low voltage did not return to boost");
  a_ceil_clear: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (!at_ceiling) |=> (ceil_cnt_r == bcc_pkg::TIMER_ZERO))
    else $error("ceiling timer kept count after voltage dropped");
  a_eq_skip: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (!eq_enabled && phase_r != bcc_pkg::BCC_EQUALISE) |=> (phase_r != bcc_pkg::BCC_EQUALISE))
    else $error("equalise entered with zero duration");
  a_abs_hold: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (phase_r == bcc_pkg::BCC_ABSORB && !abs_holding && !phase_change) |=> $stable(ph_tmr_r))
    else $error("absorption timer moved while voltage low");
  a_eq_limit: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (phase_r == bcc_pkg::BCC_EQUALISE && eq_timeout && !manual_adv && !ret_done && !boost_due)
    |=> (phase_r == after_eq))
    else $error("equalise not ended at time limit");
  a_boost_charge: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (phase_r == bcc_pkg::BCC_BOOST) |=> CHARGE_ON_O)
    else $error("charge switch off in boost");
  a_short_return: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (screen_r == bcc_pkg::BCC_SCR_PHASE && SHORT_PUSH_I && !LONG_PUSH_I && !ret_done && !boost_due && !eq_start
     && !ceil_done && !eq_done && !abs_done && !eq_timeout)
    |=> (screen_r == bcc_pkg::BCC_SCR_BATTERY && $stable(phase_r)))
    else $error("short push changed phase or kept screen");
  a_show_timer: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (screen_r == bcc_pkg::BCC_SCR_PHASE && timed_phase) |=> (SHOW_KIND_O == bcc_pkg::BCC_SHOW_TIMER))
    else $error("timed phase not showing timer");
  c_to_absorb: cover property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    phase_r == bcc_pkg::BCC_BOOST ##1 phase_r == bcc_pkg::BCC_ABSORB);
  c_to_equalise: cover property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    phase_r == bcc_pkg::BCC_FLOAT ##1 phase_r == bcc_pkg::BCC_EQUALISE);
  c_manual: cover property (@(posedge CORE_CLK_I) disable iff (SRST_I) manual_adv);
  c_return: cover property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    phase_r == bcc_pkg::BCC_FLOAT ##1 phase_r == bcc_pkg::BCC_BOOST);

endmodule
`default_nettype wire

// >>> inc/bcc_pkg.sv
// Package of constants and types for the battery charge cycle state machine
`default_nettype none
package bcc_pkg;
  // Charge phase codes shown on the phase screen
  typedef enum logic [1:0] {
    BCC_BOOST    = 2'b00,
    BCC_EQUALISE = 2'b01,
    BCC_ABSORB   = 2'b10,
    BCC_FLOAT    = 2'b11
  } bcc_phase_type;
  // Display screens
  typedef enum logic [1:0] {
    BCC_SCR_BATTERY = 2'b00,
    BCC_SCR_PHASE   = 2'b01
  } bcc_screen_type;
  // What the display value field holds
  localparam logic [1:0] BCC_SHOW_VOLTAGE = 2'h0;
  localparam logic [1:0] BCC_SHOW_TIMER   = 2'h1;
  localparam int         VOLT_W           = 12;
  localparam int         MIN_W            = 13;
  localparam int         DAY_W            = 8;
  localparam int         HOUR_W           = 5;
  localparam logic [MIN_W-1:0] CEIL_MINUTES   = 13'h0003;
  localparam logic [MIN_W-1:0] RETURN_MINUTES = 13'h000A;
  localparam int               EQ_LIMIT_DAYS  = 4;
  localparam logic [MIN_W-1:0] MIN_PER_DAY    = 13'h05A0;
  localparam logic [MIN_W-1:0] EQ_LIMIT_MIN   = 13'h1680;
  localparam logic [HOUR_W-1:0] EQ_START_HOUR = 5'h09;
  localparam logic [MIN_W-1:0] TIMER_ZERO     = 13'h0000;
  localparam logic [MIN_W-1:0] TIMER_ONE      = 13'h0001;
  localparam logic [DAY_W-1:0] DAY_ZERO       = 8'h00;
  localparam logic [DAY_W-1:0] DAY_ONE        = 8'h01;
  localparam logic [VOLT_W-1:0] VOLT_ZERO     = 12'h000;
  localparam logic [VOLT_W-1:0] VOLT_ONE      = 12'h001;
endpackage
`default_nettype wire

// >>> bench/bcc_plant_model.sv
// Far-side model: battery voltage sense plus timebase and button pulse source
`timescale 1ns/1ps
`default_nettype none
module bcc_plant_model (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        srst_i,
  // Bench requests
  input  wire logic [bcc_pkg::VOLT_W-1:0]  level_i,
  input  wire logic [3:0]                  req_i,
  // Device side
  output logic      [bcc_pkg::VOLT_W-1:0]  volt_o,
  output logic      [3:0]                  pulse_o
);
  logic [3:0] req_r;
  wire  [3:0] req_rise = req_i & ~req_r;
  // Edge detect so a request held too long still gives one pulse only
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      req_r   <= 4'h0;
      pulse_o <= 4'h0;
    end else begin
      req_r   <= req_i;
      pulse_o <= req_rise;
    end
  end
  // Sensed voltage arrives one sample late, like a converter result
  always_ff @(posedge clk_i) begin
    volt_o <= level_i;
  end
endmodule
`default_nettype wire

// >>> bench/tb_battery_charge_cycle_fsm.sv
// Self-checking bench for the battery charge cycle state machine
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("mismatch at %0t: %s", $time, msg); end end
module tb_battery_charge_cycle_fsm;
  typedef struct {
    logic [11:0]            v;
    int                     n;
    bcc_pkg::bcc_phase_type ph;
  } bcc_row_type;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        otemp = 1'b0;
  logic [4:0]  hour = 5'h00;
  logic [11:0] level = 12'h700;
  logic [3:0]  req = 4'h0;
  logic [11:0] ceil_v = 12'h800;
  logic [11:0] ret_v = 12'h600;
  logic [11:0] eq_v = 12'h900;
  logic [11:0] abs_v = 12'h700;
  logic [11:0] margin = 12'h040;
  logic [11:0] flt_v = 12'h680;
  logic [7:0]  boost_days = 8'h00;
  logic [7:0]  eq_days = 8'h10;
  logic [12:0] eq_dur = 13'h0000;
  logic [12:0] abs_dur = 13'h0005;
  logic [11:0] volt;
  logic [3:0]  pulse;
  logic        charge_on;
  logic        reduce;
  logic [1:0]  phase;
  logic [1:0]  screen;
  logic [1:0]  kind;
  logic [12:0] value;
  int          n_mismatch = 0;
  int          n_compared = 0;
  // Ceiling run broken once, then absorption with a paused timer, then float and a low-voltage return
  bcc_row_type rows [10] = '{
    '{12'h800, 2, bcc_pkg::BCC_BOOST}, '{12'h700, 1, bcc_pkg::BCC_BOOST},
    '{12'h800, 2, bcc_pkg::BCC_BOOST}, '{12'h800, 1, bcc_pkg::BCC_ABSORB},
    '{12'h6C1, 3, bcc_pkg::BCC_ABSORB}, '{12'h650, 4, bcc_pkg::BCC_ABSORB},
    '{12'h6C1, 1, bcc_pkg::BCC_ABSORB}, '{12'h6C1, 1, bcc_pkg::BCC_FLOAT},
    '{12'h500, 10, bcc_pkg::BCC_FLOAT}, '{12'h500, 1, bcc_pkg::BCC_BOOST}};

  initial begin
    forever #5 clk = ~clk;
  end

  bcc_plant_model u_plant (.clk_i(clk), .srst_i(srst), .level_i(level), .req_i(req), .volt_o(volt), .pulse_o(pulse));

  bcc_charge_fsm DUT (
    .CORE_CLK_I(clk), .SRST_I(srst), .MINUTE_TICK_I(pulse[0]), .DAY_TICK_I(pulse[1]), .HOUR_I(hour),
    .BATTERY_VOLTAGE_I(volt), .OVER_TEMP_I(otemp), .BOOST_CEILING_VOLTAGE_I(ceil_v),
    .BOOST_RETURN_VOLTAGE_I(ret_v), .BOOST_INTERVAL_DAYS_I(boost_days), .EQUALISE_VOLTAGE_I(eq_v),
    .EQUALISE_DURATION_I(eq_dur), .EQUALISE_INTERVAL_DAYS_I(eq_days), .ABSORPTION_VOLTAGE_I(abs_v),
    .ABSORPTION_DURATION_I(abs_dur), .SWITCHING_MARGIN_I(margin), .FLOAT_VOLTAGE_TARGET_I(flt_v),
    .SHORT_PUSH_I(pulse[2]), .LONG_PUSH_I(pulse[3]), .CHARGE_ON_O(charge_on), .CURRENT_REDUCE_O(reduce),
    .PHASE_O(phase), .SCREEN_O(screen), .SHOW_KIND_O(kind), .SHOW_VALUE_O(value));

  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask

  // Bit 0 minute, 1 day, 2 short push, 3 long push; waits until display outputs settle
  task automatic push(input int k);
    req[k] = 1'b1;
    step(1);
    req[k] = 1'b0;
    step(4);
  endtask

  task automatic ticks(input int n);
    repeat (n) push(0);
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // About 30k cycles are expected; allow twice that
  initial begin
    #600000;
    n_mismatch++;
    close_out();
  end

  initial begin
    step(20);
    `CHK(phase, bcc_pkg::BCC_BOOST, "reset phase")
    `CHK(screen, bcc_pkg::BCC_SCR_BATTERY, "reset screen")
    `CHK(charge_on, 1'b0, "charge during reset")
    srst = 1'b0;
    step(3);
    `CHK(charge_on, 1'b1, "boost charge on")
    for (int i = 0; i < 10; i++) begin
      level = rows[i].v;
      ticks(rows[i].n);
      `CHK(phase, rows[i].ph, "phase after row")
    end
    level = 12'h7FF;
    push(3);
    `CHK(screen, bcc_pkg::BCC_SCR_PHASE, "phase screen")
    `CHK(phase, bcc_pkg::BCC_BOOST, "phase kept")
    `CHK(kind, bcc_pkg::BCC_SHOW_VOLTAGE, "boost shows voltage")
    `CHK(value, 13'h07FF, "boost voltage value")
    push(3);
    `CHK(phase, bcc_pkg::BCC_ABSORB, "equalise skipped")
    `CHK(kind, bcc_pkg::BCC_SHOW_TIMER, "absorb shows timer")
    push(3);
    `CHK(phase, bcc_pkg::BCC_FLOAT, "manual to float")
    `CHK(kind, bcc_pkg::BCC_SHOW_VOLTAGE, "float shows voltage")
    push(3);
    `CHK(phase, bcc_pkg::BCC_BOOST, "manual to boost")
    abs_dur = 13'h0000;
    push(3);
    `CHK(phase, bcc_pkg::BCC_FLOAT, "absorb skipped")
    push(2);
    `CHK(screen, bcc_pkg::BCC_SCR_BATTERY, "short push returns")
    `CHK(phase, bcc_pkg::BCC_FLOAT, "short push keeps phase")
    level = 12'h500;
    step(3);
    `CHK(charge_on, 1'b1, "float recharge")
    level = 12'h7FF;
    boost_days = 8'h02;
    push(1);
    `CHK(phase, bcc_pkg::BCC_FLOAT, "one day early")
    push(1);
    `CHK(phase, bcc_pkg::BCC_BOOST, "forced boost")
    boost_days = 8'h00;
    push(3);
    push(3);
    eq_dur = 13'h0005;
    eq_days = 8'h01;
    abs_dur = 13'h0005;
    hour = 5'h08;
    push(1);
    `CHK(phase, bcc_pkg::BCC_FLOAT, "equalise waits for hour")
    hour = 5'h09;
    step(3);
    `CHK(phase, bcc_pkg::BCC_EQUALISE, "equalise at start hour")
    `CHK(kind, bcc_pkg::BCC_SHOW_TIMER, "equalise shows timer")
    // Voltage kept under the equalise level so only the time limit can end the phase
    ticks(5759);
    `CHK(phase, bcc_pkg::BCC_EQUALISE, "before limit")
    ticks(1);
    `CHK(phase, bcc_pkg::BCC_ABSORB, "limit to absorb")
    ticks(2);
    `CHK(value, 13'h0002, "absorb timer shown")
    otemp = 1'b1;
    step(2);
    `CHK(reduce, 1'b1, "hot reduces current")
    otemp = 1'b0;
    step(2);
    `CHK(reduce, 1'b0, "cool full current")
    push(3);
    `CHK(phase, bcc_pkg::BCC_FLOAT, "manual absorb to float")
    // Equalise that reaches its level and completes on its own timer
    level = 12'h900;
    push(1);
    ticks(4);
    `CHK(phase, bcc_pkg::BCC_EQUALISE, "equalise holding")
    `CHK(value, 13'h0004, "equalise timer")
    `CHK(charge_on, 1'b0, "equalise stops at level")
    ticks(1);
    `CHK(phase, bcc_pkg::BCC_ABSORB, "equalise done")
    srst = 1'b1;
    step(2);
    `CHK(phase, bcc_pkg::BCC_BOOST, "mid-run reset phase")
    `CHK(screen, bcc_pkg::BCC_SCR_BATTERY, "mid-run reset screen")
    `CHK(value, 13'h0000, "mid-run reset value")
    `CHK(charge_on, 1'b0, "mid-run reset charge")
    srst = 1'b0;
    step(2);
    `CHK(charge_on, 1'b1, "boost after reset")
    close_out();
  end
endmodule
`default_nettype wire
